// File: bench/apb_host.sv
// Purpose: host cpu model driving the apb side
// Assumes: called right after a rising pclk edge
// Notes:   one idle cycle follows each transfer
`timescale 1ns/1ps
module apb_host (
  // apb
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [7:0]  paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwdata  <= ~d;
    @(posedge pclk);
  endtask
endmodule

// File: bench/clock_hold_adjust_checker.sv
// Purpose: port checker for clock_hold_adjust
// Assumes: apb master keeps the hand-over contract
// Notes:   busy output mode tracked from control word 2 writes
`timescale 1ns/1ps
module clock_hold_adjust_checker
  import clk_hold_pkg::*;
#(parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF) (
  // apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // pins
  input wire logic        alarm_pulse_pin,
  input wire logic        interval_timer_pin,
  input wire logic        irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic bmode;
  wire  wr = psel && penable && pwrite && pready;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) bmode <= 1'b0;
    else if (wr && paddr == OFF_CTRL2) bmode <= pwdata[C2_BUSY_OUT];
  sequence adj_wr;
    wr && paddr == OFF_CTRL1 && pwdata[C1_ADJUST] && bmode && !alarm_pulse_pin;
  endsequence
  sequence quiet;
    (!bmode)[*3];
  endsequence
  chk_ready_access: assert property (psel && penable |-> pready) else $error("no ready in access");
  chk_ready_setup: assert property (psel && !penable |-> !pready) else $error("ready in setup");
  chk_err_place: assert property (pslverr |-> psel && penable) else $error("stray slave error");
  chk_clear_reads: assert property (psel && penable && !pwrite && paddr == OFF_IRQ_CL |-> prdata == 0 && !pslverr)
    else $error("clear register read");
  chk_busy_hold: assert property (adj_wr |-> ##[1:2] alarm_pulse_pin[*3])
    else $error("busy short after adjust");
  chk_busy_pins: assert property (alarm_pulse_pin |-> interval_timer_pin)
    else $error("pins disagree in busy mode");
  chk_alarm_idle: assert property (quiet |-> !alarm_pulse_pin)
    else $error("alarm pin high outside busy mode");
  chk_pulse_once: assert property (quiet ##0 interval_timer_pin |=> !interval_timer_pin)
    else $error("second pulse too wide");
  chk_irq_mask: assert property (wr && paddr == OFF_IRQ_EN && pwdata[IRQ_W-1:0] == 0 |-> ##2 !irq)
    else $error("irq while masked");
endmodule

// File: bench/clock_hold_adjust_test.sv
// Purpose: self-checking bench for clock_hold_adjust
// Assumes: shortened second of 20 cycles
// Notes:   irq used to find the tick phase
`timescale 1ns/1ps
module clock_hold_adjust_test;
  import clk_hold_pkg::*;
  localparam int unsigned T = 20;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr, alarm_pulse_pin, interval_timer_pin, irq, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q, s, d;
  int          mismatches = 0;
  int          num_checks = 0;
  always #5 pclk = ~pclk;
  apb_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
                 .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  clock_hold_adjust #(.TICK_CYCLES(T)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .alarm_pulse_pin(alarm_pulse_pin), .interval_timer_pin(interval_timer_pin), .irq(irq));
  function automatic logic [31:0] wrap(logic [31:0] v, logic [31:0] mx, logic c);
    return c ? ((v == mx) ? 32'h0 : v + 1) : v;
  endfunction
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    num_checks++;
    if (g !== x) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    host.xfer(1'b1, a, v, q, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input string n);
    host.xfer(1'b0, a, 32'h0, q, e);
    chk(n, x, q);
  endtask
  task automatic sync_tick;
    wr(OFF_IRQ_CL, 32'h1);
    repeat (2) @(posedge pclk);
    while (irq !== 1'b1) @(posedge pclk);
    host.xfer(1'b0, OFF_SECS, 32'h0, s, e);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #200_000;
    mismatches++;
    end_sim();
  end
  initial begin
    void'($urandom(32'h1fde_0240));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(OFF_CTRL1, 32'h0, "ctrl1");
    rd(OFF_IRQ_EN, 32'h0, "irq_en");
    rd(OFF_IRQ_CL, 32'h0, "irq_clear");
    host.xfer(1'b0, 8'h30, 32'h0, q, e);
    chk("slverr", 32'h1, {31'h0, e});
    // halt then set time, clock frozen
    s = $urandom_range(59);
    wr(OFF_CTRL1, 32'h1);
    wr(OFF_SECS, s);
    repeat (3 * T) @(posedge pclk);
    rd(OFF_SECS, s, "sec_halted");
    wr(OFF_CTRL2, 32'h1);
    wr(OFF_IRQ_EN, 32'h2);
    for (int i = 0; i < 2; i++) begin
      s = i ? $urandom_range(29) : 30 + $urandom_range(29);
      d = $urandom_range(16'hfffe);
      wr(OFF_SECS, s);
      wr(OFF_MINS, MIN_MAX);
      wr(OFF_HOURS, HOUR_MAX);
      wr(OFF_DAYS, d);
      wr(OFF_CTRL1, 32'h3);
      do host.xfer(1'b0, OFF_STATUS, 32'h0, q, e); while (q[0] !== 1'b0);
      rd(OFF_SECS, 32'h0, "sec_adj");
      rd(OFF_MINS, wrap(MIN_MAX, MIN_MAX, s >= SEC_HALF), "min_adj");
      rd(OFF_HOURS, wrap(HOUR_MAX, HOUR_MAX, s >= SEC_HALF), "hour_adj");
      rd(OFF_DAYS, d + (s >= SEC_HALF), "day_adj");
    end
    chk("irq_set", 32'h1, {31'h0, irq});
    rd(OFF_CTRL2, 32'h1, "ctrl2_kept");
    wr(OFF_IRQ_CL, 32'h3);
    host.xfer(1'b0, OFF_IRQ_ST, 32'h0, q, e);
    chk("irq_cleared", 32'h0, q & 32'h2);
    // long hold keeps one pending tick
    wr(OFF_CTRL2, 32'h0);
    wr(OFF_CTRL1, 32'h0);
    wr(OFF_IRQ_EN, 32'h1);
    sync_tick();
    wr(OFF_CTRL1, 32'h8);
    rd(OFF_STATUS, 32'h2, "held");
    repeat (3 * T + 6) @(posedge pclk);
    rd(OFF_SECS, s, "sec_held");
    wr(OFF_CTRL1, 32'h0);
    rd(OFF_SECS, (s + 1) % 60, "sec_pending");
    // short hold across a tick loses no time
    sync_tick();
    repeat (6) @(posedge pclk);
    wr(OFF_CTRL1, 32'h8);
    repeat (8) @(posedge pclk);
    wr(OFF_CTRL1, 32'h0);
    repeat (40) @(posedge pclk);
    rd(OFF_SECS, (s + 3) % 60, "sec_no_lag");
    // time write while running is ignored
    wr(OFF_SECS, (s + 30) % 60);
    rd(OFF_SECS, (s + 3) % 60, "sec_unhalted");
    wr(OFF_IRQ_EN, 32'h0);
    @(posedge pclk);
    chk("irq_masked", 32'h0, {31'h0, irq});
    end_sim();
  end
endmodule
bind clock_hold_adjust clock_hold_adjust_checker #(.TICK_CYCLES(TICK_CYCLES)) chk_i (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .alarm_pulse_pin(alarm_pulse_pin),
  .interval_timer_pin(interval_timer_pin), .irq(irq));

// File: logic/clk_hold_pkg.sv
// Purpose: shared constants for the counter hold and rounding adjust block
// Assumes: 100 MHz pclk, APB register access
// Notes:   offsets are byte addresses of 32-bit words
package clk_hold_pkg;
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned TICK_HZ_DEF     = 1;
  // one second of pclk cycles
  localparam int unsigned TICK_CYCLES_DEF = CLK_HZ / TICK_HZ_DEF;
  // sub-second steps: 32768 per second, unused; the divider counts pclk cycles
  localparam int unsigned SUB_STEPS       = 32768;
  localparam int unsigned SUB_HALF        = SUB_STEPS / 2;

  localparam logic [7:0] OFF_CTRL1  = 8'h00;
  localparam logic [7:0] OFF_CTRL2  = 8'h04;
  localparam logic [7:0] OFF_SECS   = 8'h08;
  localparam logic [7:0] OFF_MINS   = 8'h0C;
  localparam logic [7:0] OFF_HOURS  = 8'h10;
  localparam logic [7:0] OFF_DAYS   = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  localparam logic [7:0] OFF_IRQ_ST = 8'h1C;
  localparam logic [7:0] OFF_IRQ_EN = 8'h20;
  localparam logic [7:0] OFF_IRQ_CL = 8'h24;

  // control word 1 fields
  localparam int unsigned C1_STOP   = 0;
  localparam int unsigned C1_ADJUST = 1;
  localparam int unsigned C1_HOLD   = 3;
  // control word 2 fields
  localparam int unsigned C2_BUSY_OUT = 0;

  // interrupt bits
  localparam int unsigned IRQ_SECOND   = 0;
  localparam int unsigned IRQ_ADJ_DONE = 1;
  localparam int unsigned IRQ_W        = 2;

  localparam logic [5:0] SEC_MAX  = 6'h3B;
  localparam logic [5:0] MIN_MAX  = 6'h3B;
  localparam logic [4:0] HOUR_MAX = 5'h17;
  localparam logic [5:0] SEC_HALF = 6'h1E;

  typedef enum logic [2:0] {
    ADJ_IDLE  = 3'b000,
    ADJ_SEC   = 3'b001,
    ADJ_MIN   = 3'b010,
    ADJ_HOUR  = 3'b011,
    ADJ_DAY   = 3'b100
  } adj_state_t;
endpackage

// File: logic/clock_hold_adjust.sv
// Purpose: time counter with halt, read hold and rounding adjust behind APB
// Assumes: one 100 MHz clock, host keeps its own setting discipline
// Notes:   time kept in binary fields, days counter is free-running
// Notes on behaviour
// - rounding adjust to nearest minute carries through every digit including days
// - busy stays high until the adjust carry has reached every digit
// - bit 3 of control word 1 is the hold-for-read bit
// - halt or hold bit blocks the 1 Hz tick from the counter
// - release within half a second loses no time
// - busy output mode drives busy on both pins, control word 2 unchanged
//
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/1ps
module clock_hold_adjust #(
  parameter int unsigned TICK_CYCLES = clk_hold_pkg::TICK_CYCLES_DEF
) (
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // pins and interrupt
  output logic             alarm_pulse_pin,
  output logic             interval_timer_pin,
  output logic             irq
);
  import clk_hold_pkg::*;

  // one-cycle raw tick needs at least two cycles per second
  if (TICK_CYCLES < 2) begin : g_bad_cycles
    $error("clock_hold_adjust: TICK_CYCLES must be at least 2");
  end

  // ==========================================
  // state
  logic [3:0]  ctrl1_reg;
  logic [3:0]  ctrl2_reg;
  logic [5:0]  sec_reg;
  logic [5:0]  min_reg;
  logic [4:0]  hour_reg;
  logic [15:0] day_reg;
  logic [IRQ_W-1:0] irq_st_reg;
  logic [IRQ_W-1:0] irq_en_reg;
  adj_state_t  adj_reg;
  logic        tick;
  logic        raw_tick;
  logic        busy;
  logic        wr;
  logic        adj_req;
  logic        adj_done;
  logic        cnt_hold;

  assign wr       = psel && penable && pwrite;
  assign busy     = adj_reg != ADJ_IDLE;
  assign cnt_hold = ctrl1_reg[C1_STOP] || ctrl1_reg[C1_HOLD];
  assign adj_req  = wr && paddr == OFF_CTRL1 && pwdata[C1_ADJUST] && !busy;
  assign adj_done = adj_reg == ADJ_DAY;

  // ==========================================
  // tick gating
  tick_gate #(
    .CYCLES(TICK_CYCLES)
  ) u_gate (
    .pclk    (pclk),
    .presetn (presetn),
    .hold_in (cnt_hold),
    .accept  (!busy),
    .tick_out(tick),
    .raw_tick(raw_tick)
  );

  // ==========================================
  // control words
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl1_reg <= 4'h0;
      ctrl2_reg <= 4'h0;
    end else if (wr && paddr == OFF_CTRL1) begin
      ctrl1_reg <= {pwdata[3:2], 1'b0, pwdata[0]};
    end else if (wr && paddr == OFF_CTRL2) begin
      ctrl2_reg <= pwdata[3:0];
    end
  end

  // ==========================================
  // adjust sequencer, one digit group per cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adj_reg <= ADJ_IDLE;
    end else begin
      unique case (adj_reg)
        ADJ_IDLE: if (adj_req) adj_reg <= ADJ_SEC;
        ADJ_SEC:  adj_reg <= ADJ_MIN;
        ADJ_MIN:  adj_reg <= ADJ_HOUR;
        ADJ_HOUR: adj_reg <= ADJ_DAY;
        ADJ_DAY:  adj_reg <= ADJ_IDLE;
        default:  adj_reg <= ADJ_IDLE;
      endcase
    end
  end

  // ==========================================
  // time counter
  logic carry_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_reg   <= '0;
      min_reg   <= '0;
      hour_reg  <= '0;
      day_reg   <= '0;
      carry_reg <= 1'b0;
    end else if (adj_reg == ADJ_SEC) begin
      carry_reg <= sec_reg >= SEC_HALF;
      sec_reg   <= '0;
    end else if (adj_reg == ADJ_MIN) begin
      if (carry_reg) begin
        carry_reg <= min_reg == MIN_MAX;
        min_reg   <= (min_reg == MIN_MAX) ? 6'h00 : min_reg + 6'h01;
      end
    end else if (adj_reg == ADJ_HOUR) begin
      if (carry_reg) begin
        carry_reg <= hour_reg == HOUR_MAX;
        hour_reg  <= (hour_reg == HOUR_MAX) ? 5'h00 : hour_reg + 5'h01;
      end
    end else if (adj_reg == ADJ_DAY) begin
      if (carry_reg) day_reg <= day_reg + 16'h0001;
      carry_reg <= 1'b0;
    end else if (wr && ctrl1_reg[C1_STOP]) begin
      // time writes honoured only while halted
      if (paddr == OFF_SECS && pwdata[5:0] <= SEC_MAX) sec_reg <= pwdata[5:0];
      if (paddr == OFF_MINS && pwdata[5:0] <= MIN_MAX) min_reg <= pwdata[5:0];
      if (paddr == OFF_HOURS && pwdata[4:0] <= HOUR_MAX) hour_reg <= pwdata[4:0];
      if (paddr == OFF_DAYS) day_reg <= pwdata[15:0];
    end else if (tick) begin
      if (sec_reg != SEC_MAX) begin
        sec_reg <= sec_reg + 6'h01;
      end else begin
        sec_reg <= '0;
        if (min_reg != MIN_MAX) begin
          min_reg <= min_reg + 6'h01;
        end else begin
          min_reg <= '0;
          if (hour_reg != HOUR_MAX) begin
            hour_reg <= hour_reg + 5'h01;
          end else begin
            hour_reg <= '0;
            day_reg  <= day_reg + 16'h0001;
          end
        end
      end
    end
  end

  // ==========================================
  // interrupts, set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_st_reg <= '0;
      irq_en_reg <= '0;
    end else begin
      if (wr && paddr == OFF_IRQ_EN) irq_en_reg <= pwdata[IRQ_W-1:0];
      irq_st_reg <= (irq_st_reg & ~((wr && paddr == OFF_IRQ_CL) ? pwdata[IRQ_W-1:0] : '0))
                    | {adj_done, tick};
    end
  end

  // ==========================================
  // pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_pulse_pin    <= 1'b0;
      interval_timer_pin <= 1'b0;
      irq                <= 1'b0;
    end else begin
      irq <= |(irq_st_reg & irq_en_reg);
      if (ctrl2_reg[C2_BUSY_OUT]) begin
        alarm_pulse_pin    <= busy;
        interval_timer_pin <= busy;
      end else begin
        alarm_pulse_pin    <= 1'b0;
        interval_timer_pin <= raw_tick;
      end
    end
  end

  // ==========================================
  // apb read path, one wait-free access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        unique case (paddr)
          OFF_CTRL1:  prdata <= {28'h0, ctrl1_reg};
          OFF_CTRL2:  prdata <= {28'h0, ctrl2_reg};
          OFF_SECS:   prdata <= {26'h0, sec_reg};
          OFF_MINS:   prdata <= {26'h0, min_reg};
          OFF_HOURS:  prdata <= {27'h0, hour_reg};
          OFF_DAYS:   prdata <= {16'h0, day_reg};
          OFF_STATUS: prdata <= {30'h0, cnt_hold, busy};
          OFF_IRQ_ST: prdata <= {30'h0, irq_st_reg};
          OFF_IRQ_EN: prdata <= {30'h0, irq_en_reg};
          default: begin
            prdata  <= '0;
            pslverr <= !(paddr == OFF_IRQ_CL);
          end
        endcase
      end
    end
  end
endmodule

// File: logic/tick_gate.sv
// Purpose: sub-second divider and 1 Hz tick gate with one pending tick
// Assumes: hold_in is synchronous to pclk
// Notes:   divider never stops, so a short hold loses no time
`timescale 1ns/1ps
module tick_gate #(
  parameter int unsigned CYCLES = clk_hold_pkg::TICK_CYCLES_DEF
) (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // control
  input  wire logic hold_in,
  input  wire logic accept,
  // result
  output logic      tick_out,
  output logic      raw_tick
);
  import clk_hold_pkg::*;
  // divider needs a reload cycle and a counting cycle
  if (CYCLES < 2) begin : g_bad_cycles
    $error("tick_gate: CYCLES must be at least 2");
  end
  logic [31:0] div_reg;
  logic        pend_reg;

  // free-running divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg  <= '0;
      raw_tick <= 1'b0;
    end else if (div_reg == CYCLES - 1) begin
      div_reg  <= '0;
      raw_tick <= 1'b1;
    end else begin
      div_reg  <= div_reg + 32'h0000_0001;
      raw_tick <= 1'b0;
    end
  end

  // at most one tick waits while held
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_reg <= 1'b0;
    end else if (raw_tick) begin
      pend_reg <= 1'b1;
    end else if (tick_out) begin
      pend_reg <= 1'b0;
    end
  end

  assign tick_out = pend_reg && !hold_in && accept;
endmodule
